// ---- regdp_pkg.sv ----
// Package of widths, reset values, selector codes and register offsets for the register datapath
package regdp_pkg;
  localparam int DATA_W = 16;
  localparam int BUF_W = 18;
  localparam int PROT_BIT = 16;
  localparam int PAR_BIT = 17;
  localparam int OPC_W = 8;
  localparam int ADDR_W = 15;
  localparam int IRQ_W = 16;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [17:0] BUF_RST = 18'h00000;
  localparam logic [7:0] OPC_RST = 8'h00;
  localparam logic [14:0] ADDR_RST = 15'h0000;
  // AXI4-Lite byte offsets
  localparam logic [7:0] OFS_BUF = 8'h00;
  localparam logic [7:0] OFS_XCHG = 8'h04;
  localparam logic [7:0] OFS_OPC = 8'h08;
  localparam logic [7:0] OFS_ADR = 8'h0C;
  localparam logic [7:0] OFS_SADR = 8'h10;
  localparam logic [7:0] OFS_PC = 8'h14;
  localparam logic [7:0] OFS_ACC = 8'h18;
  localparam logic [7:0] OFS_AUX = 8'h1C;
  localparam logic [7:0] OFS_MASK = 8'h20;
  localparam logic [7:0] OFS_PEND = 8'h24;
  localparam logic [7:0] OFS_ALU = 8'h28;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Adder/shifter selectors
  localparam logic [1:0] AUG_ACC = 2'h0;
  localparam logic [1:0] AUG_AUX = 2'h1;
  localparam logic [1:0] AUG_PC = 2'h2;
  localparam logic [1:0] AUG_ZERO = 2'h3;
  localparam logic [1:0] ADD_XCHG = 2'h0;
  localparam logic [1:0] ADD_ADR = 2'h1;
  localparam logic [1:0] ADD_ONE = 2'h2;
  localparam logic [1:0] ADD_ZERO = 2'h3;
  typedef enum logic [2:0] {
    OP_ADD = 3'b000,
    OP_AND = 3'b001,
    OP_XOR = 3'b010,
    OP_SHL = 3'b011,
    OP_SHR = 3'b100,
    OP_PASS = 3'b101
  } alu_op_t;
endpackage : regdp_pkg

// ---- cpu_register_datapath.sv ----
// Main register set and shared adder/shifter path of the arithmetic and control unit
`timescale 1ns/1ps
// Summary of operation
// - The storage buffer is 18 bits: data in 0..15, protect in bit 16, parity in bit 17.
// - On a memory read the 16 data bits of the storage buffer move into the exchange register.
// - On a memory write the exchange register contents move into the storage buffer.
// - The 16-bit exchange register holds an operand; its top 8 bits load the opcode register.
// - The 8-bit opcode register holds operation and mode bits whose decode steers execution.
// - The 16-bit address register holds the address passed to the storage address register.
// - On multiply and shift the address register and its decrementer count iterations.
// - The address register holds partial addresses, then the final effective address.
// - The 15-bit storage address loads from the address register or an outside requester.
// - An internal storage access selects its address from the address register only.
// - The 15-bit program counter is advanced by one through the adder unless inhibited.
// - The 16-bit principal accumulator is the primary operand and result register.
// - The 16-bit auxiliary accumulator is the secondary operand register.
// - A line is recognised only when its bit in the 16-bit mask is one.
// - The shared adder/shifter carries arithmetic, logic and moves except the decrement and direct register transfers: combine, shift or pass.
// - Adder inputs come from an augend group and an addend group of four sources each.
module cpu_register_datapath
  import regdp_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Transfer strobes from control
  input wire logic mem_read_stb,
  input wire logic mem_write_stb,
  input wire logic opc_load_stb,
  input wire logic sadr_int_stb,
  input wire logic sadr_ext_stb,
  input wire logic adr_dec_stb,
  input wire logic pc_adv_stb,
  input wire logic pc_adv_inhibit,
  // Adder/shifter control
  input wire logic [1:0] aug_sel,
  input wire logic [1:0] add_sel,
  input wire logic [2:0] alu_op,
  input wire logic to_acc_stb,
  input wire logic to_aux_stb,
  input wire logic to_adr_stb,
  input wire logic to_xchg_stb,
  // Core storage side
  input wire logic [17:0] store_rdata,
  input wire logic store_rvalid,
  input wire logic [14:0] ext_addr,
  output logic [17:0] store_wdata,
  output logic [14:0] store_addr,
  // Interrupt lines
  input wire logic [15:0] irq_lines,
  output logic [15:0] irq_recognised,
  output logic irq_any,
  // Status toward control
  output logic [7:0] opcode,
  output logic iter_zero
);
  typedef struct packed {
    logic [17:0] buf_r;
    logic [15:0] xchg;
    logic [7:0] opc;
    logic [15:0] adr;
    logic [14:0] sadr;
    logic [14:0] pc;
    logic [15:0] acc;
    logic [15:0] aux;
    logic [15:0] mask;
    logic [15:0] alu_last;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = old;
    if (s[0]) begin
      merge16[7:0] = d[7:0];
    end
    if (s[1]) begin
      merge16[15:8] = d[15:8];
    end
  endfunction : merge16

  function automatic logic map_hit(input logic [7:0] a);
    map_hit = (a <= OFS_ALU) && (a[1:0] == 2'h0);
  endfunction : map_hit

  logic [15:0] augend;
  logic [15:0] addend;
  logic [15:0] alu_out;
  logic wr_fire;
  logic rd_fire;

  // Augend and addend selector groups
  always_comb begin
    unique case (aug_sel)
      AUG_ACC: augend = st_ff.acc;
      AUG_AUX: augend = st_ff.aux;
      AUG_PC: augend = {1'b0, st_ff.pc};
      AUG_ZERO: augend = WORD_RST;
    endcase
    unique case (add_sel)
      ADD_XCHG: addend = st_ff.xchg;
      ADD_ADR: addend = st_ff.adr;
      ADD_ONE: addend = 16'h0001;
      ADD_ZERO: addend = WORD_RST;
    endcase
  end

  // Shared adder/shifter
  always_comb begin
    unique case (alu_op)
      OP_ADD: alu_out = augend + addend;
      OP_AND: alu_out = augend & addend;
      OP_XOR: alu_out = augend ^ addend;
      OP_SHL: alu_out = {augend[14:0], 1'b0};
      OP_SHR: alu_out = {augend[15], augend[15:1]};
      OP_PASS: alu_out = augend | addend;
      default: alu_out = augend;
    endcase
  end

  assign wr_fire = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  always_comb begin
    nxt_st = st_ff;
    // Storage buffer: read data from core, or data to write from exchange
    if (store_rvalid) begin
      nxt_st.buf_r = store_rdata;
    end else if (mem_write_stb) begin
      nxt_st.buf_r[15:0] = st_ff.xchg;
    end
    // Exchange register
    if (mem_read_stb) begin
      nxt_st.xchg = st_ff.buf_r[15:0];
    end else if (to_xchg_stb) begin
      nxt_st.xchg = alu_out;
    end
    if (opc_load_stb) begin
      nxt_st.opc = st_ff.xchg[15:8];
    end
    // Address register: adder result or iteration decrement
    if (to_adr_stb) begin
      nxt_st.adr = alu_out;
    end else if (adr_dec_stb) begin
      nxt_st.adr = st_ff.adr - 16'h0001;
    end
    // Storage address: internal from address register, else external
    if (sadr_int_stb) begin
      nxt_st.sadr = st_ff.adr[14:0];
    end else if (sadr_ext_stb) begin
      nxt_st.sadr = ext_addr;
    end
    // Program advance through the adder with augend=pc, addend=one
    if (pc_adv_stb && !pc_adv_inhibit) begin
      nxt_st.pc = alu_out[14:0];
    end
    if (to_acc_stb) begin
      nxt_st.acc = alu_out;
    end
    if (to_aux_stb) begin
      nxt_st.aux = alu_out;
    end
    if (to_acc_stb || to_aux_stb || to_adr_stb || to_xchg_stb) begin
      nxt_st.alu_last = alu_out;
    end
    // AXI write channel
    if (s_axi_awvalid && !st_ff.aw_got) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_ff.w_got) begin
      nxt_st.w_got = 1'b1;
      nxt_st.w_data = s_axi_wdata;
      nxt_st.w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = map_hit(st_ff.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      unique case (st_ff.aw_addr)
        OFS_ACC: nxt_st.acc = merge16(st_ff.acc, st_ff.w_data, st_ff.w_strb);
        OFS_AUX: nxt_st.aux = merge16(st_ff.aux, st_ff.w_data, st_ff.w_strb);
        OFS_MASK: nxt_st.mask = merge16(st_ff.mask, st_ff.w_data, st_ff.w_strb);
        OFS_PC: nxt_st.pc = 15'(merge16({1'b0, st_ff.pc}, st_ff.w_data, st_ff.w_strb));
        default: ;
      endcase
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    // AXI read channel
    if (rd_fire) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = map_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_araddr)
        OFS_BUF: nxt_st.rdata = {14'h0000, st_ff.buf_r};
        OFS_XCHG: nxt_st.rdata = {16'h0000, st_ff.xchg};
        OFS_OPC: nxt_st.rdata = {24'h000000, st_ff.opc};
        OFS_ADR: nxt_st.rdata = {16'h0000, st_ff.adr};
        OFS_SADR: nxt_st.rdata = {17'h00000, st_ff.sadr};
        OFS_PC: nxt_st.rdata = {17'h00000, st_ff.pc};
        OFS_ACC: nxt_st.rdata = {16'h0000, st_ff.acc};
        OFS_AUX: nxt_st.rdata = {16'h0000, st_ff.aux};
        OFS_MASK: nxt_st.rdata = {16'h0000, st_ff.mask};
        OFS_PEND: nxt_st.rdata = {16'h0000, irq_lines & st_ff.mask};
        OFS_ALU: nxt_st.rdata = {16'h0000, st_ff.alu_last};
        default: nxt_st.rdata = 32'h00000000;
      endcase
    end else if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign s_axi_awready = !st_ff.aw_got;
  assign s_axi_wready = !st_ff.w_got;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_arready = !st_ff.rvalid;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;
  assign store_wdata = st_ff.buf_r;
  assign store_addr = st_ff.sadr;
  assign irq_recognised = irq_lines & st_ff.mask;
  assign irq_any = |irq_recognised;
  assign opcode = st_ff.opc;
  assign iter_zero = (st_ff.adr == WORD_RST);

  // Checks
  AST_READ_MOVE: assert property (@(posedge aclk) disable iff (!aresetn)
    mem_read_stb |=> st_ff.xchg == $past(st_ff.buf_r[15:0]))
    else $error("exchange did not take buffer data");
  AST_WRITE_MOVE: assert property (@(posedge aclk) disable iff (!aresetn)
    mem_write_stb && !store_rvalid |=> store_wdata[15:0] == $past(st_ff.xchg))
    else $error("buffer did not take exchange data");
  AST_OPC_LOAD: assert property (@(posedge aclk) disable iff (!aresetn)
    opc_load_stb |=> opcode == $past(st_ff.xchg[15:8]))
    else $error("opcode not loaded from upper exchange bits");
  AST_ITER_DEC: assert property (@(posedge aclk) disable iff (!aresetn)
    adr_dec_stb && !to_adr_stb |=> st_ff.adr == $past(st_ff.adr) - 16'h0001)
    else $error("iteration count not decremented");
  AST_SADR_INT: assert property (@(posedge aclk) disable iff (!aresetn)
    sadr_int_stb |=> store_addr == $past(st_ff.adr[14:0]))
    else $error("internal access not addressed by address register");
  AST_SADR_EXT: assert property (@(posedge aclk) disable iff (!aresetn)
    sadr_ext_stb && !sadr_int_stb |=> store_addr == $past(ext_addr))
    else $error("external address not taken");
  AST_PC_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    pc_adv_inhibit && !wr_fire |=> $stable(st_ff.pc))
    else $error("program counter moved while inhibited");
  AST_MASK: assert property (@(posedge aclk) disable iff (!aresetn)
    irq_any |-> |(irq_lines & st_ff.mask))
    else $error("interrupt recognised on masked line");
  AST_ACC_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    !to_acc_stb && !wr_fire |=> $stable(st_ff.acc))
    else $error("accumulator changed without strobe");
  AST_BUF_LOAD: assert property (@(posedge aclk) disable iff (!aresetn)
    store_rvalid |=> store_wdata == $past(store_rdata))
    else $error("buffer did not take the core word");
  AST_FLAG_KEEP: assert property (@(posedge aclk) disable iff (!aresetn)
    mem_write_stb && !store_rvalid |=> store_wdata[17:16] == $past(store_wdata[17:16]))
    else $error("protect or parity bit changed on a data write");
  AST_ADR_LOAD: assert property (@(posedge aclk) disable iff (!aresetn)
    to_adr_stb |=> st_ff.adr == $past(alu_out))
    else $error("address register did not take adder result");
  AST_PC_ADV: assert property (@(posedge aclk) disable iff (!aresetn)
    pc_adv_stb && !pc_adv_inhibit && !wr_fire && aug_sel == AUG_PC && add_sel == ADD_ONE
    && alu_op == OP_ADD |=> st_ff.pc == $past(st_ff.pc) + 15'h0001)
    else $error("program counter not advanced by one");
  AST_ACC_LOAD: assert property (@(posedge aclk) disable iff (!aresetn)
    to_acc_stb && !wr_fire |=> st_ff.acc == $past(alu_out))
    else $error("accumulator did not take adder result");
  AST_AUX_LOAD: assert property (@(posedge aclk) disable iff (!aresetn)
    to_aux_stb && !wr_fire |=> st_ff.aux == $past(alu_out))
    else $error("auxiliary register did not take adder result");
  AST_XCHG_LOAD: assert property (@(posedge aclk) disable iff (!aresetn)
    to_xchg_stb && !mem_read_stb |=> st_ff.xchg == $past(alu_out))
    else $error("exchange register did not take adder result");
  AST_PASS_PATH: assert property (@(posedge aclk) disable iff (!aresetn)
    alu_op == OP_PASS && add_sel == ADD_ZERO |-> alu_out == augend)
    else $error("pass path altered the operand");
  AST_RDATA_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped or changed before taken");
  AST_BRESP_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped or changed before taken");

  // Main scenarios
  COV_READ: cover property (@(posedge aclk) mem_read_stb ##1 opc_load_stb);
  COV_PC: cover property (@(posedge aclk) pc_adv_stb && !pc_adv_inhibit);
  COV_AXI_W: cover property (@(posedge aclk) s_axi_bvalid && s_axi_bready);
  COV_ITER: cover property (@(posedge aclk) adr_dec_stb ##1 iter_zero);
  COV_SADR_EXT: cover property (@(posedge aclk) sadr_ext_stb && !sadr_int_stb);
endmodule : cpu_register_datapath

// ---- core_store_model.sv ----
// Core storage model with a fixed read latency and a released data bus
`timescale 1ns/1ps
module core_store_model #(
  parameter int LAT = 3
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Requests from the bench
  input wire logic rd_req,
  input wire logic wr_req,
  // Storage port of the datapath
  input wire logic [14:0] store_addr,
  input wire logic [17:0] store_wdata,
  output logic [17:0] store_rdata,
  output logic store_rvalid
);
  logic [17:0] mem [32];
  logic [17:0] last;
  int cnt;
  initial begin
    for (int i = 0; i < 32; i++) begin
      mem[i] = 18'h2C3A5 ^ 18'(i);
    end
  end
  always @(posedge aclk) begin
    store_rvalid <= 1'b0;
    if (!aresetn) begin
      cnt <= 0;
      last <= 18'h00000;
    end else if (rd_req) begin
      cnt <= LAT;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) begin
        store_rvalid <= 1'b1;
        last <= mem[store_addr[4:0]];
      end
    end
    if (wr_req) begin
      mem[store_addr[4:0]] <= store_wdata;
    end
  end
  // Released bus shows the inverted last word
  assign store_rdata = store_rvalid ? last : ~last;
endmodule : core_store_model

// ---- cpu_register_datapath_tb.sv ----
// Self-checking bench for the register datapath
`timescale 1ns/1ps
module cpu_register_datapath_tb
  import regdp_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] aw_a = 8'h00;
  logic [7:0] ar_a = 8'h00;
  logic [31:0] w_d = 32'h00000000;
  logic [3:0] w_s = 4'hF;
  logic aw_v = 1'b0;
  logic w_v = 1'b0;
  logic b_r = 1'b0;
  logic ar_v = 1'b0;
  logic r_r = 1'b0;
  logic [13:0] stb = 14'h0000;
  logic [1:0] aug = 2'h0;
  logic [1:0] add = 2'h0;
  logic [2:0] aop = 3'h0;
  logic [14:0] ext = 15'h0005;
  logic [15:0] irq = 16'h0000;
  logic aw_r, w_r, b_v, ar_r, r_v, rv, any, iz;
  logic [1:0] b_resp, r_resp;
  logic [31:0] r_d;
  logic [15:0] rec;
  logic [17:0] rdat, wdat;
  logic [14:0] sadr;
  logic [7:0] opc;
  int fails = 0;
  int n_checks = 0;

  initial begin
    forever #10 aclk = ~aclk;
  end

  cpu_register_datapath i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r),
    .s_axi_wdata(w_d), .s_axi_wstrb(w_s), .s_axi_wvalid(w_v), .s_axi_wready(w_r),
    .s_axi_bresp(b_resp), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
    .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r),
    .s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
    .mem_read_stb(stb[0]), .mem_write_stb(stb[1]), .opc_load_stb(stb[2]),
    .sadr_int_stb(stb[3]), .sadr_ext_stb(stb[4]), .adr_dec_stb(stb[5]),
    .pc_adv_stb(stb[6]), .pc_adv_inhibit(stb[7]), .aug_sel(aug), .add_sel(add),
    .alu_op(aop), .to_acc_stb(stb[8]), .to_aux_stb(stb[9]), .to_adr_stb(stb[10]),
    .to_xchg_stb(stb[11]), .store_rdata(rdat), .store_rvalid(rv), .ext_addr(ext),
    .store_wdata(wdat), .store_addr(sadr), .irq_lines(irq), .irq_recognised(rec),
    .irq_any(any), .opcode(opc), .iter_zero(iz)
  );

  core_store_model #(.LAT(3)) i_store (
    .aclk(aclk), .aresetn(aresetn), .rd_req(stb[12]), .wr_req(stb[13]),
    .store_addr(sadr), .store_wdata(wdat), .store_rdata(rdat), .store_rvalid(rv)
  );

  task automatic complete_run();
    if (fails == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic tmo(input int n);
    if (n >= 50) begin
      fails++;
      complete_run();
    end
  endtask : tmo

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    bit ta;
    bit tw;
    n = 0;
    ta = 0;
    tw = 0;
    @(posedge aclk);
    aw_a <= a;
    w_d <= d;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= 1'b1;
    while (!(ta && tw) && n < 50) begin
      @(posedge aclk);
      n++;
      if (aw_r === 1'b1 && !ta) begin
        ta = 1;
        aw_v <= 1'b0;
      end
      if (w_r === 1'b1 && !tw) begin
        tw = 1;
        w_v <= 1'b0;
      end
    end
    do begin
      @(posedge aclk);
      n++;
    end while (b_v !== 1'b1 && n < 50);
    b_r <= 1'b0;
    tmo(n);
    chk("bresp", 32'(er), 32'(b_resp));
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    ar_a <= a;
    ar_v <= 1'b1;
    r_r <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (ar_r !== 1'b1 && n < 50);
    ar_v <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (r_v !== 1'b1 && n < 50);
    r_r <= 1'b0;
    tmo(n);
    chk("rdata", ed, r_d);
    chk("rresp", 32'(er), 32'(r_resp));
  endtask : axi_rd

  // One strobe cycle, then one edge so the load shows
  task automatic step(input logic [13:0] s, input logic [1:0] ag, input logic [1:0] ad,
                      input logic [2:0] op);
    stb <= s;
    aug <= ag;
    add <= ad;
    aop <= op;
    @(posedge aclk);
    stb <= 14'h0000;
    @(posedge aclk);
  endtask : step

  initial begin
    logic [15:0] e [4];
    int n;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(OFS_PC, 32'h00000000, RESP_OKAY);
    axi_wr(OFS_ACC, 32'h00001234, RESP_OKAY);
    axi_wr(OFS_MASK, 32'h000000F0, RESP_OKAY);
    axi_wr(OFS_PC, 32'h00000003, RESP_OKAY);
    axi_wr(OFS_BUF, 32'h00001111, RESP_OKAY);
    axi_wr(8'h30, 32'h00000001, RESP_SLVERR);
    axi_rd(8'h30, 32'h00000000, RESP_SLVERR);
    step(14'h0010, AUG_ZERO, ADD_ZERO, OP_PASS);
    chk("sadr", 32'h00000005, 32'(sadr));
    step(14'h1000, AUG_ZERO, ADD_ZERO, OP_PASS);
    n = 0;
    while (rv !== 1'b1 && n < 50) begin
      @(posedge aclk);
      n++;
    end
    @(posedge aclk);
    tmo(n);
    axi_rd(OFS_BUF, 32'h0002C3A0, RESP_OKAY);
    step(14'h0001, AUG_ZERO, ADD_ZERO, OP_PASS);
    axi_rd(OFS_XCHG, 32'h0000C3A0, RESP_OKAY);
    step(14'h0004, AUG_ZERO, ADD_ZERO, OP_PASS);
    chk("opcode", 32'h000000C3, 32'(opc));
    axi_rd(OFS_OPC, 32'h000000C3, RESP_OKAY);
    e = '{16'hD5D4, 16'h0220, 16'hD194, 16'h0000};
    for (int k = 0; k < 3; k++) begin
      step(14'h0200, AUG_ACC, ADD_XCHG, 3'(k));
      axi_rd(OFS_AUX, 32'(e[k]), RESP_OKAY);
    end
    axi_rd(OFS_ALU, 32'h0000D194, RESP_OKAY);
    step(14'h0100, AUG_ACC, ADD_ZERO, OP_SHL);
    step(14'h0800, AUG_AUX, ADD_ZERO, OP_SHR);
    axi_rd(OFS_ACC, 32'h00002468, RESP_OKAY);
    axi_rd(OFS_XCHG, 32'h0000E8CA, RESP_OKAY);
    e = '{16'h2468, 16'hD194, 16'h0003, 16'h0000};
    for (int k = 0; k < 4; k++) begin
      step(14'h0400, 2'(k), ADD_ZERO, OP_PASS);
      axi_rd(OFS_ADR, 32'(e[k]), RESP_OKAY);
    end
    e = '{16'hE8CA, 16'hE8CA, 16'h0001, 16'h0000};
    for (int k = 0; k < 4; k++) begin
      step(14'h0400, AUG_ZERO, 2'(k), OP_PASS);
      axi_rd(OFS_ADR, 32'(e[k]), RESP_OKAY);
    end
    step(14'h0400, AUG_PC, ADD_ZERO, OP_PASS);
    step(14'h0018, AUG_ZERO, ADD_ZERO, OP_PASS);
    chk("sadr", 32'h00000003, 32'(sadr));
    axi_rd(OFS_SADR, 32'h00000003, RESP_OKAY);
    step(14'h0020, AUG_ZERO, ADD_ZERO, OP_PASS);
    step(14'h0020, AUG_ZERO, ADD_ZERO, OP_PASS);
    chk("iter", 32'h00000000, 32'(iz));
    step(14'h0020, AUG_ZERO, ADD_ZERO, OP_PASS);
    chk("iter", 32'h00000001, 32'(iz));
    step(14'h0040, AUG_PC, ADD_ONE, OP_ADD);
    step(14'h00C0, AUG_PC, ADD_ONE, OP_ADD);
    axi_rd(OFS_PC, 32'h00000004, RESP_OKAY);
    step(14'h0002, AUG_ZERO, ADD_ZERO, OP_PASS);
    chk("wdata", 32'h0002E8CA, 32'(wdat));
    step(14'h2000, AUG_ACC, ADD_XCHG, OP_ADD);
    axi_rd(OFS_ACC, 32'h00002468, RESP_OKAY);
    irq <= 16'h0FF0;
    @(posedge aclk);
    chk("irq", 32'h000100F0, {15'h0000, any, rec});
    axi_rd(OFS_PEND, 32'h000000F0, RESP_OKAY);
    irq <= 16'h0F0F;
    @(posedge aclk);
    chk("irq", 32'h00000000, {15'h0000, any, rec});
    // High byte lane only
    w_s <= 4'h2;
    axi_wr(OFS_MASK, 32'h0000AB55, RESP_OKAY);
    w_s <= 4'hF;
    axi_rd(OFS_MASK, 32'h0000ABF0, RESP_OKAY);
    chk("irq", 32'h00010B00, {15'h0000, any, rec});
    // Reset in mid-run clears the registers
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(OFS_ACC, 32'h00000000, RESP_OKAY);
    chk("irq", 32'h00000000, {15'h0000, any, rec});
    complete_run();
  end
endmodule : cpu_register_datapath_tb
